// ==== core/dma_pkg.sv ====
package dma_pkg;
    // control byte field positions
    localparam int CTL_EN_BIT = 7;
    localparam int CTL_LOOP_BIT = 6;
    localparam int CTL_DIR_BIT = 5;
    localparam int CTL_IRQ_BIT = 4;
    localparam int CTL_WORD_BIT = 3;
    localparam int CTL_SRC_MSB = 2;
    localparam int CTL_SRC_LSB = 0;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [2:0] SRC_NONE = 3'h7;
    // configuration field selectors
    localparam logic [2:0] SEL_CTL = 3'h0;
    localparam logic [2:0] SEL_IO = 3'h1;
    localparam logic [2:0] SEL_HI = 3'h2;
    localparam logic [2:0] SEL_START = 3'h3;
    localparam logic [2:0] SEL_END = 3'h4;
    // peripheral space upper nibble
    localparam logic [3:0] PER_HI_NIBBLE = 4'hF;
    localparam logic [11:0] ADDR_RESET = 12'h000;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [2:0] ADC_IN_RESET = 3'h0;
    // address steps
    localparam logic [11:0] STEP_BYTE = 12'h001;
    localparam logic [11:0] STEP_WORD = 12'h002;
    // bus owners
    typedef enum logic [1:0] {OWN_CH0, OWN_CH1, OWN_ADC} owner_t;
    typedef enum {ST_IDLE, ST_REQ, ST_RD, ST_CAP, ST_WR, ST_FIN} bus_state_t;
endpackage

// ==== core/dma_chan_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// channel-to-arbiter bundle
interface dma_chan_if;
    logic pend; // transfer waiting
    logic dir; // 1: peripheral to register file
    logic word; // two-byte transfers
    logic [11:0] per_addr; // peripheral side address
    logic [11:0] cur_addr; // register file current address
    logic served; // one-cycle pulse, transfer finished
    modport chan (output pend, dir, word, per_addr, cur_addr, input served);
    modport ctrl (input pend, dir, word, per_addr, cur_addr, output served);
endinterface
`default_nettype wire

// ==== core/dma_periph_chan.sv ====
`timescale 1ns/1ps
`default_nettype none
module dma_periph_chan (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic cfg_we_i,
    input wire logic [2:0] cfg_sel_i,
    input wire logic [7:0] cfg_data_i,
    input wire logic [6:0] trig_i,
    output logic enable_o,
    output logic irq_o,
    dma_chan_if.chan bus
);
    logic [7:0] ctl_reg; // control byte
    logic [7:0] io_reg; // peripheral_address_byte
    logic [7:0] hi_reg; // address_high_nibbles
    logic [7:0] start_reg; // start low byte
    logic [7:0] end_reg; // end low byte
    logic [11:0] cur_reg; // current address
    logic pend_reg; // latched trigger
    logic irq_reg; // interrupt pulse
    logic [11:0] start_addr;
    logic [11:0] end_addr;
    logic [11:0] cur_next;
    logic trig_hit;
    logic at_end;

    ////////////////////////////////////////////////////////////////////////
    // address forming
    assign start_addr = {hi_reg[3:0], start_reg};
    assign end_addr = {hi_reg[7:4], end_reg};
    assign at_end = (cur_reg == end_addr);
    assign bus.per_addr = {dma_pkg::PER_HI_NIBBLE, io_reg};
    assign bus.cur_addr = cur_reg;
    assign bus.dir = ctl_reg[dma_pkg::CTL_DIR_BIT];
    assign bus.word = ctl_reg[dma_pkg::CTL_WORD_BIT];
    assign bus.pend = pend_reg;
    assign enable_o = ctl_reg[dma_pkg::CTL_EN_BIT];
    assign irq_o = irq_reg;

    // selected trigger source, reserved code selects nothing
    always_comb begin
        trig_hit = 1'b0;
        if (ctl_reg[dma_pkg::CTL_SRC_MSB:dma_pkg::CTL_SRC_LSB] != dma_pkg::SRC_NONE) begin
            trig_hit = trig_i[ctl_reg[dma_pkg::CTL_SRC_MSB:dma_pkg::CTL_SRC_LSB]];
        end
    end

    // next current address after a transfer
    always_comb begin
        if (at_end) begin
            cur_next = start_addr;
        end else if (ctl_reg[dma_pkg::CTL_WORD_BIT]) begin
            cur_next = cur_reg + dma_pkg::STEP_WORD;
        end else begin
            cur_next = cur_reg + dma_pkg::STEP_BYTE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control byte; software write wins over hardware self-disable
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctl_reg <= dma_pkg::CTL_RESET;
        end else if (cfg_we_i && cfg_sel_i == dma_pkg::SEL_CTL) begin
            ctl_reg <= cfg_data_i;
        end else if (bus.served && at_end && !ctl_reg[dma_pkg::CTL_LOOP_BIT]) begin
            ctl_reg[dma_pkg::CTL_EN_BIT] <= 1'b0;
        end
    end

    // address setup bytes
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            io_reg <= dma_pkg::BYTE_RESET;
            hi_reg <= dma_pkg::BYTE_RESET;
            start_reg <= dma_pkg::BYTE_RESET;
            end_reg <= dma_pkg::BYTE_RESET;
        end else if (cfg_we_i) begin
            case (cfg_sel_i)
                dma_pkg::SEL_IO: io_reg <= cfg_data_i;
                dma_pkg::SEL_HI: hi_reg <= cfg_data_i;
                dma_pkg::SEL_START: start_reg <= cfg_data_i;
                dma_pkg::SEL_END: end_reg <= cfg_data_i;
                default: ;
            endcase
        end
    end

    // current address: start write loads it, transfer steps it
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cur_reg <= dma_pkg::ADDR_RESET;
        end else if (cfg_we_i && cfg_sel_i == dma_pkg::SEL_START) begin
            cur_reg <= {hi_reg[3:0], cfg_data_i};
        end else if (bus.served) begin
            cur_reg <= cur_next;
        end
    end

    // pending request; a new trigger wins over the serve clear
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pend_reg <= 1'b0;
        end else if (!ctl_reg[dma_pkg::CTL_EN_BIT]) begin
            pend_reg <= 1'b0;
        end else if (trig_hit) begin
            pend_reg <= 1'b1;
        end else if (bus.served) begin
            pend_reg <= 1'b0;
        end
    end

    // end-of-block interrupt pulse
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= bus.served && at_end && ctl_reg[dma_pkg::CTL_IRQ_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_end_reload: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        bus.served && at_end |=> cur_reg == $past(start_addr))
        else $error("current address not reloaded at end");
    a_single_pass_off: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        bus.served && at_end && !ctl_reg[dma_pkg::CTL_LOOP_BIT] && !cfg_we_i
        |=> !enable_o)
        else $error("single pass channel still enabled");
    a_step_size: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        bus.served && !at_end && !cfg_we_i
        |=> cur_reg == $past(cur_reg) + (bus.word ? 12'h002 : 12'h001))
        else $error("current address step wrong");
    a_disabled_idle: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !enable_o |=> !pend_reg)
        else $error("disabled channel holds a request");
endmodule
`default_nettype wire

// ==== core/dma_controller.sv ====
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - two peripheral channels plus converter channel
// - peripheral channel moves in configured direction
// - trigger makes channel request the bus
// - after grant move byte/word, release bus
// - at end address reload start, interrupt
// - single pass clears enable at end
// - otherwise advance by one or two
// - peripheral address is F plus address byte
// - start/end built from shared high nibbles
// - control selects loop, direction, irq, size, source
// - converter done makes channel request bus
// - granted converter channel writes two bytes
// - after highest input restart at zero, interrupt
// - otherwise convert next higher input
// - disabled channel ignores triggers
module dma_controller (
    input wire logic clk_i,
    input wire logic arst_n_i,
    // peripheral channel configuration
    input wire logic [1:0] cfg_we_i,
    input wire logic [2:0] cfg_sel_i,
    input wire logic [7:0] cfg_data_i,
    input wire logic [6:0] trig0_i,
    input wire logic [6:0] trig1_i,
    output logic [1:0] chan_enable_o,
    output logic [1:0] chan_irq_o,
    // converter channel
    input wire logic adc_enable_i,
    input wire logic adc_irq_en_i,
    input wire logic [2:0] adc_top_input_i,
    input wire logic [6:0] adc_base_i,
    input wire logic adc_done_i,
    input wire logic [15:0] adc_data_i,
    output logic [2:0] adc_input_o,
    output logic adc_start_o,
    output logic adc_irq_o,
    // system bus
    output logic bus_req_o,
    input wire logic bus_ack_i,
    output logic [11:0] mem_addr_o,
    output logic mem_re_o,
    output logic mem_we_o,
    output logic [7:0] mem_wdata_o,
    input wire logic [7:0] mem_rdata_i
);
    dma_chan_if ch0_bus ();
    dma_chan_if ch1_bus ();

    dma_pkg::bus_state_t state_reg;
    dma_pkg::owner_t owner_reg;
    logic byte_reg; // byte index within word
    logic [11:0] addr_reg;
    logic re_reg;
    logic we_reg;
    logic [7:0] data_reg;
    logic [15:0] adc_res_reg; // latched conversion result
    logic adc_pend_reg;
    logic [2:0] adc_in_reg;
    logic adc_start_reg;
    logic adc_irq_reg;
    logic last_byte;
    logic xfer_dir;
    logic [11:0] per_a;
    logic [11:0] mem_a;
    logic [11:0] src_a;
    logic [11:0] dst_a;
    logic adc_last;

    ////////////////////////////////////////////////////////////////////////
    // the two peripheral channels
    dma_periph_chan u_ch0 (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .cfg_we_i(cfg_we_i[0]),
        .cfg_sel_i(cfg_sel_i),
        .cfg_data_i(cfg_data_i),
        .trig_i(trig0_i),
        .enable_o(chan_enable_o[0]),
        .irq_o(chan_irq_o[0]),
        .bus(ch0_bus.chan)
    );
    dma_periph_chan u_ch1 (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .cfg_we_i(cfg_we_i[1]),
        .cfg_sel_i(cfg_sel_i),
        .cfg_data_i(cfg_data_i),
        .trig_i(trig1_i),
        .enable_o(chan_enable_o[1]),
        .irq_o(chan_irq_o[1]),
        .bus(ch1_bus.chan)
    );

    ////////////////////////////////////////////////////////////////////////
    // per-owner addressing for the active byte
    always_comb begin
        per_a = ch0_bus.per_addr;
        mem_a = ch0_bus.cur_addr;
        xfer_dir = ch0_bus.dir;
        last_byte = !ch0_bus.word || byte_reg;
        case (owner_reg)
            dma_pkg::OWN_CH0: ;
            dma_pkg::OWN_CH1: begin
                per_a = ch1_bus.per_addr;
                mem_a = ch1_bus.cur_addr;
                xfer_dir = ch1_bus.dir;
                last_byte = !ch1_bus.word || byte_reg;
            end
            dma_pkg::OWN_ADC: begin
                mem_a = {adc_base_i, 1'b0, adc_in_reg, 1'b0};
                xfer_dir = 1'b1;
                last_byte = byte_reg;
            end
            default: ;
        endcase
        per_a = per_a + {11'h000, byte_reg};
        mem_a = mem_a + {11'h000, byte_reg};
        src_a = xfer_dir ? per_a : mem_a;
        dst_a = xfer_dir ? mem_a : per_a;
    end

    assign ch0_bus.served = (state_reg == dma_pkg::ST_FIN) && (owner_reg == dma_pkg::OWN_CH0);
    assign ch1_bus.served = (state_reg == dma_pkg::ST_FIN) && (owner_reg == dma_pkg::OWN_CH1);
    assign adc_last = (adc_in_reg >= adc_top_input_i);

    ////////////////////////////////////////////////////////////////////////
    // bus sequencer: request, read (skipped for converter), capture, write, release
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= dma_pkg::ST_IDLE;
            owner_reg <= dma_pkg::OWN_CH0;
            byte_reg <= 1'b0;
        end else begin
            case (state_reg)
                dma_pkg::ST_IDLE: begin
                    byte_reg <= 1'b0;
                    if (!bus_ack_i) begin
                        if (ch0_bus.pend) begin
                            owner_reg <= dma_pkg::OWN_CH0;
                            state_reg <= dma_pkg::ST_REQ;
                        end else if (ch1_bus.pend) begin
                            owner_reg <= dma_pkg::OWN_CH1;
                            state_reg <= dma_pkg::ST_REQ;
                        end else if (adc_pend_reg) begin
                            owner_reg <= dma_pkg::OWN_ADC;
                            state_reg <= dma_pkg::ST_REQ;
                        end
                    end
                end
                dma_pkg::ST_REQ: begin
                    if (bus_ack_i) begin
                        state_reg <= (owner_reg == dma_pkg::OWN_ADC) ?
                            dma_pkg::ST_CAP : dma_pkg::ST_RD;
                    end
                end
                dma_pkg::ST_RD: state_reg <= dma_pkg::ST_CAP;
                dma_pkg::ST_CAP: state_reg <= dma_pkg::ST_WR;
                dma_pkg::ST_WR: begin
                    if (last_byte) begin
                        state_reg <= dma_pkg::ST_FIN;
                    end else begin
                        byte_reg <= 1'b1;
                        state_reg <= (owner_reg == dma_pkg::OWN_ADC) ?
                            dma_pkg::ST_CAP : dma_pkg::ST_RD;
                    end
                end
                dma_pkg::ST_FIN: state_reg <= dma_pkg::ST_IDLE;
                default: state_reg <= dma_pkg::ST_IDLE;
            endcase
        end
    end

    // registered bus strobes, address and write data
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            addr_reg <= dma_pkg::ADDR_RESET;
            re_reg <= 1'b0;
            we_reg <= 1'b0;
            data_reg <= dma_pkg::BYTE_RESET;
        end else begin
            re_reg <= (state_reg == dma_pkg::ST_RD);
            we_reg <= (state_reg == dma_pkg::ST_CAP);
            if (state_reg == dma_pkg::ST_RD) begin
                addr_reg <= src_a;
            end else if (state_reg == dma_pkg::ST_CAP) begin
                addr_reg <= dst_a;
                if (owner_reg == dma_pkg::OWN_ADC) begin
                    data_reg <= byte_reg ? adc_res_reg[7:0] : adc_res_reg[15:8];
                end else begin
                    data_reg <= mem_rdata_i;
                end
            end
        end
    end

    assign bus_req_o = (state_reg == dma_pkg::ST_REQ) || (state_reg == dma_pkg::ST_RD)
        || (state_reg == dma_pkg::ST_CAP) || (state_reg == dma_pkg::ST_WR);
    assign mem_addr_o = addr_reg;
    assign mem_re_o = re_reg;
    assign mem_we_o = we_reg;
    assign mem_wdata_o = data_reg;

    ////////////////////////////////////////////////////////////////////////
    // converter channel: result latch, pending flag (set wins)
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            adc_pend_reg <= 1'b0;
            adc_res_reg <= 16'h0000;
        end else if (adc_done_i && adc_enable_i) begin
            adc_pend_reg <= 1'b1;
            adc_res_reg <= adc_data_i;
        end else if (state_reg == dma_pkg::ST_FIN && owner_reg == dma_pkg::OWN_ADC) begin
            adc_pend_reg <= 1'b0;
        end
    end

    // input stepping, conversion start and end-of-scan interrupt
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            adc_in_reg <= dma_pkg::ADC_IN_RESET;
            adc_start_reg <= 1'b0;
            adc_irq_reg <= 1'b0;
        end else begin
            adc_start_reg <= 1'b0;
            adc_irq_reg <= 1'b0;
            if (!adc_enable_i) begin
                adc_in_reg <= dma_pkg::ADC_IN_RESET;
            end else if (state_reg == dma_pkg::ST_FIN && owner_reg == dma_pkg::OWN_ADC) begin
                adc_start_reg <= 1'b1;
                if (adc_last) begin
                    adc_in_reg <= dma_pkg::ADC_IN_RESET;
                    adc_irq_reg <= adc_irq_en_i;
                end else begin
                    adc_in_reg <= adc_in_reg + 3'h1;
                end
            end
        end
    end

    assign adc_input_o = adc_in_reg;
    assign adc_start_o = adc_start_reg;
    assign adc_irq_o = adc_irq_reg;

    ////////////////////////////////////////////////////////////////////////
    sequence s_granted;
        state_reg == dma_pkg::ST_REQ && bus_ack_i;
    endsequence
    sequence s_released;
        ##[2:12] state_reg == dma_pkg::ST_FIN ##1 !bus_req_o;
    endsequence

    a_no_move_unowned: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (mem_re_o || mem_we_o) |-> bus_ack_i)
        else $error("bus strobe without grant");
    a_grant_release: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        s_granted |-> s_released)
        else $error("bus not returned after transfer");
    a_req_on_pend: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        state_reg == dma_pkg::ST_IDLE && !bus_ack_i && ch0_bus.pend
        |=> bus_req_o && owner_reg == dma_pkg::OWN_CH0)
        else $error("first channel not granted priority");
    a_adc_writes: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        s_granted ##0 owner_reg == dma_pkg::OWN_ADC |-> ##2 mem_we_o ##2 mem_we_o)
        else $error("converter result not written as two bytes");
    a_adc_wrap: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        state_reg == dma_pkg::ST_FIN && owner_reg == dma_pkg::OWN_ADC && adc_last
        && adc_enable_i |=> adc_input_o == 3'h0 && adc_start_o
        && adc_irq_o == $past(adc_irq_en_i))
        else $error("converter scan did not wrap to input zero");
    a_adc_next: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        state_reg == dma_pkg::ST_FIN && owner_reg == dma_pkg::OWN_ADC && !adc_last
        && adc_enable_i |=> adc_input_o == $past(adc_in_reg) + 3'h1 && !adc_irq_o)
        else $error("converter did not step to next input");
    a_adc_req: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        adc_done_i && adc_enable_i |=> adc_pend_reg)
        else $error("converter done not latched");
    a_per_addr_hi: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        mem_re_o && owner_reg != dma_pkg::OWN_ADC && xfer_dir
        |-> mem_addr_o[11:8] == 4'hF)
        else $error("peripheral read outside peripheral space");
endmodule
`default_nettype wire

// ==== verif/bus_partner_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// cpu bus arbiter and register file stand-in
module bus_partner_model (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [3:0] ack_delay_i,
    input wire logic bus_req_i,
    output logic bus_ack_o,
    input wire logic [11:0] mem_addr_i,
    input wire logic mem_re_i,
    input wire logic mem_we_i,
    input wire logic [7:0] mem_wdata_i,
    output logic [7:0] mem_rdata_o
);
    logic [7:0] mem [0:4095]; // whole 12-bit space, bench pokes it too
    logic [3:0] wait_cnt; // cycles the request has waited
    logic [7:0] last_rd = 8'h00; // last byte handed out
    //////////////////////////////////////////////////////////////////
    // grant after a programmable wait, withdraw with the request
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bus_ack_o <= 1'b0;
            wait_cnt <= 4'h0;
        end else if (!bus_req_i) begin
            bus_ack_o <= 1'b0; // bus handed back
            wait_cnt <= 4'h0;
        end else if (wait_cnt >= ack_delay_i) begin
            bus_ack_o <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
    //////////////////////////////////////////////////////////////////
    // storage, strobes taken at the edge
    always @(posedge clk_i) begin
        if (mem_we_i) begin
            mem[mem_addr_i] <= mem_wdata_i;
        end
        if (mem_re_i) begin
            last_rd <= mem[mem_addr_i];
        end
    end
    // outside a read the data lines show the inverse of the last byte
    assign mem_rdata_o = mem_re_i ? mem[mem_addr_i] : ~last_rd;
endmodule
`default_nettype wire

// ==== verif/dma_controller_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module dma_controller_tb_top;
    logic clk_i = 1'b0, arst_n_i = 1'b0;
    logic [1:0] cfg_we_i = 2'h0;
    logic [2:0] cfg_sel_i = 3'h0, adc_top_input_i = 3'h0;
    logic [7:0] cfg_data_i = 8'h00;
    logic [6:0] trig0_i = 7'h00, trig1_i = 7'h00, adc_base_i = 7'h00;
    logic adc_enable_i = 1'b0, adc_irq_en_i = 1'b0, adc_done_i = 1'b0;
    logic [15:0] adc_data_i = 16'h0000;
    logic [1:0] chan_enable_o, chan_irq_o;
    logic [2:0] adc_input_o;
    logic adc_start_o, adc_irq_o, bus_req_o, bus_ack_i, mem_re_o, mem_we_o, req_q;
    logic [11:0] mem_addr_o;
    logic [7:0] mem_wdata_o, mem_rdata_i;
    logic [3:0] ack_delay = 4'h3; // slow grant first
    int bad_count = 0, tests_run = 0, cycles = 0, s = 0;
    int irq0_n = 0, irq1_n = 0, airq_n = 0, start_n = 0, req_n = 0;
    logic [11:0] wlog [$]; // addresses of bus writes
    always #50 clk_i = ~clk_i;
    dma_controller u_dma_controller (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .cfg_we_i(cfg_we_i), .cfg_sel_i(cfg_sel_i),
        .cfg_data_i(cfg_data_i), .trig0_i(trig0_i), .trig1_i(trig1_i),
        .chan_enable_o(chan_enable_o), .chan_irq_o(chan_irq_o), .adc_enable_i(adc_enable_i),
        .adc_irq_en_i(adc_irq_en_i), .adc_top_input_i(adc_top_input_i), .adc_base_i(adc_base_i),
        .adc_done_i(adc_done_i), .adc_data_i(adc_data_i), .adc_input_o(adc_input_o),
        .adc_start_o(adc_start_o), .adc_irq_o(adc_irq_o), .bus_req_o(bus_req_o),
        .bus_ack_i(bus_ack_i), .mem_addr_o(mem_addr_o), .mem_re_o(mem_re_o),
        .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i));
    bus_partner_model u_bus_partner_model (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .ack_delay_i(ack_delay), .bus_req_i(bus_req_o),
        .bus_ack_o(bus_ack_i), .mem_addr_i(mem_addr_o), .mem_re_i(mem_re_o),
        .mem_we_i(mem_we_o), .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));
    //////////////////////////////////////////////////////////////////
    // pulse counters, write log and hang guard (run needs under 2000 cycles)
    always @(posedge clk_i) begin
        cycles++;
        irq0_n += int'(chan_irq_o[0] === 1'b1);
        irq1_n += int'(chan_irq_o[1] === 1'b1);
        airq_n += int'(adc_irq_o === 1'b1);
        start_n += int'(adc_start_o === 1'b1);
        req_n += int'(bus_req_o === 1'b1 && req_q !== 1'b1);
        req_q = bus_req_o;
        if (mem_we_o === 1'b1) begin
            wlog.push_back(mem_addr_o);
        end
        if (cycles == 20000) begin
            bad_count++;
            print_verdict();
        end
    end
    //////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one configuration write for channel ch
    task automatic cfg(input int ch, input logic [2:0] sel, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        cfg_we_i[ch] = 1'b1;
        cfg_sel_i = sel;
        cfg_data_i = d;
        @(posedge clk_i);
        #1;
        cfg_we_i = 2'h0;
    endtask
    // full channel setup in software order
    task automatic prog(input int ch, input logic [7:0] io, hi, st, en, ctl);
        cfg(ch, dma_pkg::SEL_IO, io);
        cfg(ch, dma_pkg::SEL_HI, hi);
        cfg(ch, dma_pkg::SEL_START, st);
        cfg(ch, dma_pkg::SEL_END, en);
        cfg(ch, dma_pkg::SEL_CTL, ctl);
    endtask
    // one-cycle trigger pulse on source src
    task automatic trig(input int ch, input int src);
        @(posedge clk_i);
        #1;
        if (ch == 0) trig0_i[src] = 1'b1;
        else trig1_i[src] = 1'b1;
        @(posedge clk_i);
        #1;
        trig0_i = 7'h00;
        trig1_i = 7'h00;
    endtask
    // bounded wait for one bus tenure to start and end
    task automatic wait_bus();
        int n;
        n = 0;
        while (bus_req_o !== 1'b1 && n < 40) begin
            @(posedge clk_i);
            n++;
        end
        while (bus_req_o !== 1'b0 && n < 80) begin
            @(posedge clk_i);
            n++;
        end
        repeat (4) @(posedge clk_i);
        #1;
        check({15'h0000, n < 80}, 16'h0001);
    endtask
    task automatic conv_done(input logic [15:0] d);
        @(posedge clk_i);
        #1;
        adc_done_i = 1'b1;
        adc_data_i = d;
        @(posedge clk_i);
        #1;
        adc_done_i = 1'b0;
    endtask
    function automatic logic [15:0] pair(input logic [11:0] a);
        return {u_bus_partner_model.mem[a], u_bus_partner_model.mem[a + 12'h001]};
    endfunction
    //////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk_i);
        #1;
        arst_n_i = 1'b1;
        check({chan_enable_o, adc_input_o, bus_req_o}, 16'h0000);
        // first channel: byte, to register file, single pass, 1FF..200
        u_bus_partner_model.mem[12'hF42] = 8'hA5;
        prog(0, 8'h42, 8'h21, 8'hFF, 8'h00, 8'hB0);
        check(chan_enable_o, 2'h1);
        trig(0, 0);
        wait_bus();
        check(u_bus_partner_model.mem[12'h1FF], 8'hA5);
        u_bus_partner_model.mem[12'hF42] = 8'h3C;
        trig(0, 0);
        wait_bus();
        check(u_bus_partner_model.mem[12'h200], 8'h3C);
        check(irq0_n, 1);
        check(chan_enable_o, 2'h0);
        s = req_n;
        trig(0, 0);
        repeat (10) @(posedge clk_i);
        #1;
        check(req_n, s);
        // second channel: word, to peripheral, loop, source 6, even address
        ack_delay = 4'h0;
        {u_bus_partner_model.mem[12'h320], u_bus_partner_model.mem[12'h321]} = 16'h1122;
        {u_bus_partner_model.mem[12'h322], u_bus_partner_model.mem[12'h323]} = 16'h3344;
        prog(1, 8'h50, 8'h33, 8'h20, 8'h22, 8'hDE);
        trig(1, 5);
        repeat (10) @(posedge clk_i);
        #1;
        check(req_n, s);
        trig(1, 6);
        wait_bus();
        check(pair(12'hF50), 16'h1122);
        trig(1, 6);
        wait_bus();
        check(pair(12'hF50), 16'h3344);
        check(irq1_n, 1);
        check(chan_enable_o, 2'h2);
        u_bus_partner_model.mem[12'h320] = 8'h77;
        trig(1, 6);
        wait_bus();
        check(u_bus_partner_model.mem[12'hF50], 8'h77);
        // converter channel: inputs 0 and 1, single-shot converter
        adc_base_i = 7'h05;
        adc_top_input_i = 3'h1;
        adc_irq_en_i = 1'b1;
        adc_enable_i = 1'b1;
        repeat (2) @(posedge clk_i);
        #1;
        s = start_n;
        conv_done(16'h1234);
        wait_bus();
        check(pair(12'h0A0), 16'h1234);
        check({adc_input_o, 5'(start_n - s), 8'(airq_n)}, {3'h1, 5'h01, 8'h00});
        conv_done(16'hBEEF);
        wait_bus();
        check(pair(12'h0A2), 16'hBEEF);
        check({adc_input_o, 5'(start_n - s), 8'(airq_n)}, {3'h0, 5'h02, 8'h01});
        // all three at once: fixed order of service
        prog(0, 8'h42, 8'h21, 8'hFF, 8'h00, 8'hB0);
        wlog.delete();
        // converter now scans input 0 alone with its interrupt off
        adc_irq_en_i = 1'b0;
        adc_top_input_i = 3'h0;
        @(posedge clk_i);
        #1;
        {trig0_i[0], trig1_i[6], adc_done_i, adc_data_i} = {3'h7, 16'hCAFE};
        @(posedge clk_i);
        #1;
        {trig0_i[0], trig1_i[6], adc_done_i} = 3'h0;
        repeat (3) wait_bus();
        check(wlog.size(), 5);
        check(wlog[0], 12'h1FF);
        check(wlog[1], 12'hF50);
        check(wlog[3], 12'h0A0);
        check(pair(12'h0A0), 16'hCAFE);
        check({adc_input_o, 5'(start_n - s), 8'(airq_n)}, {3'h0, 5'h03, 8'h01});
        print_verdict();
    end
endmodule
`default_nettype wire
